// ---- hdl/ctf_codec.sv ----
// symbol-pair-2/3 transmit modulator and receive bit framer with two config registers
// assumes a byte register port on sys_clk, quarter-bit strobes and demodulated bits from the front end
// How it works
// R1 - miller enable applies modified Miller pulse coding; meant with pulse position 1h
// R2 - pulse position selects none, bit start, second half, or last quarter
// R3 - invert bit inverts transmitter output while transmission is active
// R4 - envelope field combines bit stream: direct, Manchester, subcarrier, BPSK, two RZ forms
// R5 - halt-on-inverse-parity ends reception on a wrong parity bit
// R6 - halt-on-length takes length from first byte, stops when byte count reaches it
// R7 - high-bit-leading assembles bytes MSB first, else LSB first
// R8 - stop-bit check expects, verifies and strips a stop bit after each character
// R9 - each valid stop bit pulses a demodulator reset while checking is on
// R10 - wrong stop bit raises frame error and aborts reception
// R11 - a valid stop bit is always logic 1
// R12 - parity odd select: even parity when clear, odd when set
// R13 - reserved bits read zero and writes to them change nothing
`timescale 1ns/10ps
module ctf_codec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // transmitter: symbol-pair-2/3 stream, quarter-bit strobe and subcarrier from the front end
  input wire logic txActive,
  input wire logic txBit,
  input wire logic txQuarterTick,
  input wire logic txSubcarrier,
  output logic txOut,
  // receiver: demodulated bits from the front end
  input wire logic rxEnable,
  input wire logic rxBitIn,
  input wire logic rxBitStrobe,
  output logic demodReset,
  output logic frameError,
  output logic rxBusy,
  // delivered bytes toward the contactless coprocessor
  output ctf_pkg::ctf_rxbyte_t rxWord,
  output logic rxValid,
  input wire logic rxReady
);
  import ctf_pkg::*;
  // ==========================================================
  // registers
  logic [7:0] txMod_reg;
  logic [7:0] rxFrm_reg;
  ctf_txcfg_t txCfg;
  ctf_rxcfg_t rxCfg;
  assign txCfg = ctf_txcfg_t'(txMod_reg[MILLER_BIT:ENV_LO]);
  assign rxCfg = '{haltInvPar: rxFrm_reg[HALT_PAR_BIT], haltLen: rxFrm_reg[HALT_LEN_BIT],
    msbFirst: rxFrm_reg[MSB_FIRST_BIT], stopChk: rxFrm_reg[STOP_CHK_BIT], parOdd: rxFrm_reg[PAR_ODD_BIT]};
  // host writes, reserved bits masked off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txMod_reg <= REG_RESET;
      rxFrm_reg <= REG_RESET;
    end else if (regWrEn) begin
      if (regAddr == TX_SYM23_MOD_ADDR) begin
        txMod_reg <= regWrData & TX_SYM23_MOD_MASK; // R13
      end
      if (regAddr == RX_BIT_FRAME_ADDR) begin
        rxFrm_reg <= regWrData & RX_BIT_FRAME_MASK; // R13
      end
    end
  end
  // registered read data, unmapped reads as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= REG_RESET;
    end else if (regRdEn) begin
      case (regAddr)
        TX_SYM23_MOD_ADDR: regRdData <= txMod_reg;
        RX_BIT_FRAME_ADDR: regRdData <= rxFrm_reg;
        default: regRdData <= REG_RESET;
      endcase
    end
  end
  // ==========================================================
  // input synchronisers (pins from the analogue front end)
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {txQuarterTick, txSubcarrier, rxBitIn, rxBitStrobe, txBit, txActive};
      sync2_reg <= sync1_reg;
    end
  end
  logic qTickLvl, subcarrier, rxBitS, rxStrobeLvl, txBitS, txActS;
  assign {qTickLvl, subcarrier, rxBitS, rxStrobeLvl, txBitS, txActS} = sync2_reg;
  // edge detect on the synchronised strobes
  logic qTickDly_reg, rxStrobeDly_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      qTickDly_reg <= 1'b0;
      rxStrobeDly_reg <= 1'b0;
    end else begin
      qTickDly_reg <= qTickLvl;
      rxStrobeDly_reg <= rxStrobeLvl;
    end
  end
  logic qTick, rxStrobe;
  assign qTick = qTickLvl && !qTickDly_reg;
  assign rxStrobe = rxStrobeLvl && !rxStrobeDly_reg;
  // ==========================================================
  // transmit: quarter-bit phase, bit latched at each bit start
  logic [1:0] phase_reg;
  logic curBit_reg;
  logic prevBit_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
      curBit_reg <= 1'b0;
      prevBit_reg <= 1'b0;
    end else if (!txActS) begin
      phase_reg <= PHASE_START;
    end else if (qTick) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == PHASE_LAST) begin
        prevBit_reg <= curBit_reg;
        curBit_reg <= txBitS;
      end
    end
  end
  // envelope, pulse and inversion
  logic envOut, pulseOn, txNext, firstHalf;
  assign firstHalf = !phase_reg[1];
  always_comb begin
    case (txCfg.envSel) // R4
      ENV_DIRECT: envOut = curBit_reg;
      ENV_MANCH: envOut = curBit_reg ^ !firstHalf;
      ENV_MANCH_SC: envOut = (curBit_reg ^ !firstHalf) & subcarrier;
      ENV_BPSK: envOut = curBit_reg ^ subcarrier;
      ENV_RZ_SECOND: envOut = curBit_reg & !firstHalf;
      ENV_RZ_START: envOut = curBit_reg & firstHalf;
      default: envOut = 1'b0;
    endcase
    case (txCfg.pulsePos) // R2
      PULSE_START: pulseOn = (phase_reg == PHASE_START);
      PULSE_HALF: pulseOn = (phase_reg == PHASE_HALF);
      PULSE_QUARTER: pulseOn = (phase_reg == PHASE_LAST);
      default: pulseOn = 1'b0;
    endcase
    // modified Miller: one keeps mid pulse, zero after zero pulses at start, zero after one stays flat
    if (txCfg.millerEn) begin // R1
      pulseOn = curBit_reg ? (phase_reg == PHASE_HALF) : (!prevBit_reg && phase_reg == PHASE_START);
    end
    if (txCfg.pulsePos != PULSE_NONE || txCfg.millerEn) begin
      txNext = !pulseOn;
    end else begin
      txNext = envOut;
    end
    txNext = txActS && (txNext ^ txCfg.invert); // R3
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txOut <= 1'b0;
    end else begin
      txOut <= txNext;
    end
  end
  // ==========================================================
  // receive framer
  typedef enum {RX_IDLE, RX_RUN, RX_DONE} ctf_rxst_t;
  ctf_rxst_t rxSt_reg;
  logic [3:0] bitIdx_reg;
  logic [7:0] shift_reg;
  logic parAcc_reg;
  logic [7:0] frameLen_reg;
  logic [7:0] byteCnt_reg;
  logic bufInReady, pushByte, parSlot, stopSlot;
  logic parityOk, charEnd, lenHit;
  ctf_rxbyte_t pushWord;
  assign parSlot = rxStrobe && rxSt_reg == RX_RUN && bitIdx_reg == PAR_SLOT;
  assign stopSlot = rxStrobe && rxSt_reg == RX_RUN && bitIdx_reg == STOP_SLOT;
  assign parityOk = (parAcc_reg ^ rxBitS) == rxCfg.parOdd; // R12
  assign charEnd = rxCfg.stopChk ? stopSlot : parSlot;
  // with stop check the count already holds this byte; the first byte is its own length
  assign lenHit = rxCfg.haltLen && (rxCfg.stopChk ? byteCnt_reg : byteCnt_reg + COUNT_ONE)
    >= ((byteCnt_reg == 8'h00) ? shift_reg : frameLen_reg); // R6
  // bit assembly, parity accumulation and framing state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_reg <= RX_IDLE;
      bitIdx_reg <= 4'h0;
      shift_reg <= 8'h00;
      parAcc_reg <= 1'b0;
      pushWord <= '0;
      pushByte <= 1'b0;
      frameError <= 1'b0;
      demodReset <= 1'b0;
      frameLen_reg <= 8'h00;
      byteCnt_reg <= 8'h00;
    end else begin
      pushByte <= 1'b0;
      demodReset <= 1'b0;
      case (rxSt_reg)
        RX_IDLE: begin
          if (rxEnable) begin
            rxSt_reg <= RX_RUN;
            frameError <= 1'b0;
            bitIdx_reg <= 4'h0;
            parAcc_reg <= 1'b0;
            byteCnt_reg <= 8'h00;
          end
        end
        RX_RUN: begin
          if (!rxEnable) begin
            rxSt_reg <= RX_IDLE;
          end else if (rxStrobe && bufInReady) begin
            bitIdx_reg <= bitIdx_reg + 4'h1;
            if (bitIdx_reg < DATA_BITS) begin
              parAcc_reg <= parAcc_reg ^ rxBitS;
              shift_reg <= rxCfg.msbFirst ? {shift_reg[6:0], rxBitS} : {rxBitS, shift_reg[7:1]}; // R7
            end
            if (parSlot) begin
              pushWord <= '{data: shift_reg, parityOk: parityOk};
              pushByte <= 1'b1;
              if (byteCnt_reg == 8'h00) begin
                frameLen_reg <= shift_reg; // R6
              end
              byteCnt_reg <= byteCnt_reg + COUNT_ONE;
              if (rxCfg.haltInvPar && !parityOk) begin
                rxSt_reg <= RX_DONE; // R5
              end
            end
            if (stopSlot) begin // R8
              if (rxBitS != STOP_VALUE) begin // R11
                frameError <= 1'b1; // R10
                rxSt_reg <= RX_DONE; // R10
              end else begin
                demodReset <= 1'b1; // R9
              end
            end
            if (charEnd) begin
              bitIdx_reg <= 4'h0;
              parAcc_reg <= 1'b0;
              if (lenHit) begin
                rxSt_reg <= RX_DONE; // R6
              end
            end
          end
        end
        RX_DONE: begin
          if (!rxEnable) begin
            rxSt_reg <= RX_IDLE;
          end
        end
        default: rxSt_reg <= RX_IDLE;
      endcase
    end
  end
  // busy flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBusy <= 1'b0;
    end else begin
      rxBusy <= (rxSt_reg == RX_RUN);
    end
  end
  // delivered-byte buffer
  ctf_skid_buf u_buf (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inWord(pushWord),
    .inValid(pushByte),
    .inReady(bufInReady),
    .outWord(rxWord),
    .outValid(rxValid),
    .outReady(rxReady)
  );
  // ==========================================================
  // checks
  a_stop_bad_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stopSlot && bufInReady && rxCfg.stopChk && rxEnable && !rxBitS) |=> frameError) // R10
    else $error("bad stop bit did not raise frame error");
  a_stop_good_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (stopSlot && bufInReady && rxCfg.stopChk && rxEnable && rxBitS) |=> demodReset) // R9
    else $error("good stop bit gave no demodulator reset");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((txMod_reg & ~TX_SYM23_MOD_MASK) == 8'h00) && ((rxFrm_reg & ~RX_BIT_FRAME_MASK) == 8'h00)) // R13
    else $error("reserved bit stored");
  a_invpar_halt: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (parSlot && bufInReady && rxEnable && rxCfg.haltInvPar && !parityOk) |=> (rxSt_reg == RX_DONE)) // R5
    else $error("inverse parity did not halt");
  a_tx_idle_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!txActS && !txCfg.invert) |=> !txOut) // R3
    else $error("transmit output active while idle");
endmodule

// ---- hdl/ctf_pkg.sv ----
// package for the contactless symbol-pair-2/3 modulation and receive bit framing block
// assumes one 250 MHz system clock and a byte-wide register port from the host logic
package ctf_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] TX_SYM23_MOD_ADDR = 8'h57;
  localparam logic [7:0] RX_BIT_FRAME_ADDR = 8'h58;
  localparam logic [7:0] TX_SYM23_MOD_MASK = 8'h7F;
  localparam logic [7:0] RX_BIT_FRAME_MASK = 8'h3E;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================
  // field positions, modulation register
  localparam int MILLER_BIT = 6;
  localparam int PULSE_HI = 5;
  localparam int PULSE_LO = 4;
  localparam int INVERT_BIT = 3;
  localparam int ENV_HI = 2;
  localparam int ENV_LO = 0;
  // field positions, framing register
  localparam int HALT_PAR_BIT = 5;
  localparam int HALT_LEN_BIT = 4;
  localparam int MSB_FIRST_BIT = 3;
  localparam int STOP_CHK_BIT = 2;
  localparam int PAR_ODD_BIT = 1;
  // ==========================================================
  // pulse and envelope codes
  localparam logic [1:0] PULSE_NONE = 2'h0;
  localparam logic [1:0] PULSE_START = 2'h1;
  localparam logic [1:0] PULSE_HALF = 2'h2;
  localparam logic [1:0] PULSE_QUARTER = 2'h3;
  localparam logic [2:0] ENV_DIRECT = 3'h0;
  localparam logic [2:0] ENV_MANCH = 3'h1;
  localparam logic [2:0] ENV_MANCH_SC = 3'h2;
  localparam logic [2:0] ENV_BPSK = 3'h3;
  localparam logic [2:0] ENV_RZ_SECOND = 3'h4;
  localparam logic [2:0] ENV_RZ_START = 3'h5;
  // ==========================================================
  // bit timing: quarter-bit phase counter, data bits per character
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_START = 2'h0;
  localparam logic [1:0] PHASE_HALF = 2'h2;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] PAR_SLOT = 4'h8;
  localparam logic [3:0] STOP_SLOT = 4'h9;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic STOP_VALUE = 1'b1;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic millerEn;
    logic [1:0] pulsePos;
    logic invert;
    logic [2:0] envSel;
  } ctf_txcfg_t;
  typedef struct packed {
    logic haltInvPar;
    logic haltLen;
    logic msbFirst;
    logic stopChk;
    logic parOdd;
  } ctf_rxcfg_t;
  typedef struct packed {
    logic [7:0] data;
    logic parityOk;
  } ctf_rxbyte_t;
endpackage

// ---- hdl/ctf_skid_buf.sv ----
// two-entry buffer with valid and ready on both sides
// assumes both sides on sys_clk; a stall on the drain side fills it and then drops inReady
`timescale 1ns/10ps
module ctf_skid_buf (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire ctf_pkg::ctf_rxbyte_t inWord,
  input wire logic inValid,
  output logic inReady,
  // drain side
  output ctf_pkg::ctf_rxbyte_t outWord,
  output logic outValid,
  input wire logic outReady
);
  import ctf_pkg::*;
  ctf_rxbyte_t outWord_reg;
  ctf_rxbyte_t skidWord_reg;
  logic outValid_reg;
  logic skidValid_reg;
  logic drainFree;
  // ==========================================================
  // handshake terms: the skid slot fills only while the output slot stalls
  assign drainFree = !outValid_reg || outReady;
  assign inReady = !skidValid_reg;
  assign outWord = outWord_reg; // drain side straight from flip-flops
  assign outValid = outValid_reg;
  // output slot and skid slot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outWord_reg <= '0;
      outValid_reg <= 1'b0;
      skidWord_reg <= '0;
      skidValid_reg <= 1'b0;
    end else if (drainFree) begin
      if (skidValid_reg) begin
        outWord_reg <= skidWord_reg;
        outValid_reg <= 1'b1;
        skidValid_reg <= 1'b0;
      end else begin
        outWord_reg <= inWord;
        outValid_reg <= inValid;
      end
    end else if (inValid && inReady) begin
      skidWord_reg <= inWord;
      skidValid_reg <= 1'b1;
    end
  end
  a_buf_no_overflow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(inValid && !inReady))
    else $error("word offered while buffer full");
endmodule

// ---- sim/ctf_card_model.sv ----
// card side model: sends characters on the demodulated bit and strobe pins
// assumes sys_clk from the bench; pins change just after a rising edge
`timescale 1ns/10ps
module ctf_card_model (
  // clock
  input wire logic sys_clk,
  // demodulated bit pins toward the framer
  output logic rxBitIn,
  output logic rxBitStrobe
);
  // ==========================================================
  // idle state of the pins
  initial begin
    rxBitIn = 1'b0;
    rxBitStrobe = 1'b0;
  end

  // ==========================================================
  // one bit: data set up, strobe two cycles later, data flips after hold
  task automatic send_bit(input logic b);
    @(posedge sys_clk);
    rxBitIn <= b;
    repeat (2) @(posedge sys_clk);
    rxBitStrobe <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rxBitStrobe <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rxBitIn <= ~b; // stale value never lingers
  endtask

  // one character: eight data bits, parity, optional stop bit
  task automatic send_char(input logic [7:0] d, input logic msb, input logic odd,
                           input logic badPar, input logic stopOn, input logic stopVal);
    for (int i = 0; i < 8; i++) begin
      send_bit(msb ? d[7 - i] : d[i]);
    end
    send_bit(^d ^ odd ^ badPar);
    if (stopOn) begin
      send_bit(stopVal);
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// ---- sim/contactless_tx_sym_rx_bit_framing_test.sv ----
// bench for the symbol-pair-2/3 modulator and receive bit framer
// assumes ctf_pkg compiled first and the card model on the bit pins
`timescale 1ns/10ps
module contactless_tx_sym_rx_bit_framing_test;
  import ctf_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic txActive;
  logic txBit;
  logic txQuarterTick = 1'b0;
  logic txSubcarrier;
  logic txOut;
  logic rxEnable;
  logic rxBitIn;
  logic rxBitStrobe;
  logic demodReset;
  logic frameError;
  logic rxBusy;
  ctf_rxbyte_t rxWord;
  logic rxValid;
  logic rxReady;
  int numErrors = 0;
  int checked = 0;
  int pulses = 0;

  ctf_codec ctf_codec_i (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .txActive(txActive), .txBit(txBit),
    .txQuarterTick(txQuarterTick), .txSubcarrier(txSubcarrier), .txOut(txOut), .rxEnable(rxEnable),
    .rxBitIn(rxBitIn), .rxBitStrobe(rxBitStrobe), .demodReset(demodReset), .frameError(frameError),
    .rxBusy(rxBusy), .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady));
  ctf_card_model ctf_card_model_i (.sys_clk(sys_clk), .rxBitIn(rxBitIn), .rxBitStrobe(rxBitStrobe));

  // ==========================================================
  // clock and demodulator reset pulse counter
  always #2 sys_clk = ~sys_clk;
  // free-running quarter-bit strobe: one rising edge every two cycles
  always @(posedge sys_clk) begin
    txQuarterTick <= ~txQuarterTick;
  end
  always @(posedge sys_clk) begin
    if (demodReset === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // ==========================================================
  // compare, verdict, register and delivery tasks
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic reg_rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(posedge sys_clk);
    #1 check(name, {1'b0, regRdData}, {1'b0, exp});
  endtask
  // wait for a delivered word under a bound, compare, then accept it
  task automatic take(input string name, input logic [8:0] exp);
    int n;
    n = 0;
    #1;
    while (rxValid !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("rxValid", {8'h00, rxValid}, 9'h001);
    check(name, rxWord, exp);
    @(posedge sys_clk);
    rxReady <= 1'b1;
    @(posedge sys_clk);
    rxReady <= 1'b0;
  endtask
  // low cycles of the transmit output over two whole bit periods
  task automatic low_count(input string name, input int exp);
    int lows;
    lows = 0;
    repeat (16) begin
      @(posedge sys_clk);
      #1 if (txOut === 1'b0) lows++;
    end
    check(name, lows[8:0], exp[8:0]);
  endtask
  task automatic frame(input logic on);
    @(posedge sys_clk);
    rxEnable <= on;
    repeat (4) @(posedge sys_clk);
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #80000;
    numErrors++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {regAddr, regWrData, regWrEn, regRdEn} = 18'h00000;
    {txActive, txBit, txSubcarrier} = 3'h0;
    {rxEnable, rxReady} = 2'h0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, reserved masks, unmapped place
    reg_rd("modReset", TX_SYM23_MOD_ADDR, REG_RESET);
    reg_rd("frameReset", RX_BIT_FRAME_ADDR, REG_RESET);
    reg_wr(TX_SYM23_MOD_ADDR, 8'hFF);
    reg_rd("modMask", TX_SYM23_MOD_ADDR, 8'h7F);
    reg_wr(RX_BIT_FRAME_ADDR, 8'hFF);
    reg_rd("frameMask", RX_BIT_FRAME_ADDR, 8'h3E);
    reg_wr(8'h59, 8'hFF);
    reg_rd("unmapped", 8'h59, 8'h00);
    // every pulse and envelope code is stored
    for (int c = 0; c < 6; c++) begin
      reg_wr(TX_SYM23_MOD_ADDR, {2'h0, c[1:0], 1'b0, c[2:0]});
      reg_rd("modCode", TX_SYM23_MOD_ADDR, {2'h0, c[1:0], 1'b0, c[2:0]});
    end
    reg_wr(TX_SYM23_MOD_ADDR, 8'h50);
    reg_rd("millerCode", TX_SYM23_MOD_ADDR, 8'h50);
    // direct envelope follows the bit, invert flips it
    reg_wr(TX_SYM23_MOD_ADDR, 8'h00);
    txActive <= 1'b1;
    txBit <= 1'b1;
    repeat (16) @(posedge sys_clk);
    #1 check("txDirectOne", {8'h00, txOut}, 9'h001);
    txBit <= 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 check("txDirectZero", {8'h00, txOut}, 9'h000);
    reg_wr(TX_SYM23_MOD_ADDR, 8'h08);
    repeat (16) @(posedge sys_clk);
    #1 check("txInvert", {8'h00, txOut}, 9'h001);
    // pulse forms and envelopes, counted as low cycles over two bit periods
    reg_wr(TX_SYM23_MOD_ADDR, 8'h20);
    repeat (16) @(posedge sys_clk);
    low_count("txPulseHalf", 4);
    reg_wr(TX_SYM23_MOD_ADDR, 8'h50);
    txBit <= 1'b1;
    repeat (16) @(posedge sys_clk);
    low_count("txMiller", 4);
    reg_wr(TX_SYM23_MOD_ADDR, 8'h01);
    repeat (16) @(posedge sys_clk);
    low_count("txManchester", 8);
    reg_wr(TX_SYM23_MOD_ADDR, 8'h0C);
    repeat (16) @(posedge sys_clk);
    low_count("txRzInvert", 8);
    // even parity, low bit first, stop bit checked and stripped
    reg_wr(RX_BIT_FRAME_ADDR, 8'h04);
    frame(1'b1);
    ctf_card_model_i.send_char(8'hA5, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    take("lsbFirst", {8'hA5, 1'b1});
    check("demodPulse", pulses[8:0], 9'h001);
    frame(1'b0);
    // odd parity, high bit first
    reg_wr(RX_BIT_FRAME_ADDR, 8'h0A);
    frame(1'b1);
    ctf_card_model_i.send_char(8'h31, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    take("msbFirst", {8'h31, 1'b1});
    frame(1'b0);
    // receiver stalls over two words, one with wrong parity, no halt
    reg_wr(RX_BIT_FRAME_ADDR, 8'h00);
    frame(1'b1);
    ctf_card_model_i.send_char(8'h3C, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    ctf_card_model_i.send_char(8'h0F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    take("badParity", {8'h3C, 1'b0});
    take("afterBad", {8'h0F, 1'b1});
    frame(1'b0);
    // halt on inverse parity
    reg_wr(RX_BIT_FRAME_ADDR, 8'h20);
    frame(1'b1);
    ctf_card_model_i.send_char(8'h55, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    take("haltPar", {8'h55, 1'b0});
    check("busyHaltPar", {8'h00, rxBusy}, 9'h000);
    ctf_card_model_i.send_char(8'h66, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("noWordPar", {8'h00, rxValid}, 9'h000);
    frame(1'b0);
    // halt on frame length of two bytes
    reg_wr(RX_BIT_FRAME_ADDR, 8'h10);
    frame(1'b1);
    ctf_card_model_i.send_char(8'h02, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    take("lenByte", {8'h02, 1'b1});
    check("busyLen", {8'h00, rxBusy}, 9'h001);
    ctf_card_model_i.send_char(8'h44, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    take("lenData", {8'h44, 1'b1});
    check("busyLenDone", {8'h00, rxBusy}, 9'h000);
    ctf_card_model_i.send_char(8'h77, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("noWordLen", {8'h00, rxValid}, 9'h000);
    frame(1'b0);
    // wrong stop bit aborts, next reception clears the flag
    reg_wr(RX_BIT_FRAME_ADDR, 8'h04);
    frame(1'b1);
    ctf_card_model_i.send_char(8'h12, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    take("badStopWord", {8'h12, 1'b1});
    check("frameError", {8'h00, frameError}, 9'h001);
    check("busyAbort", {8'h00, rxBusy}, 9'h000);
    check("noPulseBad", pulses[8:0], 9'h001);
    frame(1'b0);
    frame(1'b1);
    ctf_card_model_i.send_char(8'h13, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    take("goodStop", {8'h13, 1'b1});
    check("errorCleared", {8'h00, frameError}, 9'h000);
    check("pulseAgain", pulses[8:0], 9'h002);
    frame(1'b0);
    end_sim();
  end
endmodule
